// file: rtl/fts_scheduler.v
// The register addresses and the APB register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "fts_defines.vh"

module fts_scheduler #(
   parameter CYC_PER_MS = 250000,
   parameter MS_PER_HOUR = 3600000,
   parameter N_FDI = 10,
   parameter N_FDO = 4
) (
   // clock and reset
   input wire i_core_clk,
   input wire i_reset,
   // apb slave
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [7:0] i_paddr,
   input wire [31:0] i_pwdata,
   output reg o_pready,
   output reg [31:0] o_prdata,
   output reg o_pslverr,
   // request sources
   input wire i_req_terminal,
   input wire i_req_process_data_word,
   input wire i_safe_torque_off_selected,
   input wire i_chan_ok,
   // fail-safe i/o
   input wire [N_FDI-1:0] i_failsafe_input,
   input wire [N_FDO-1:0] i_failsafe_output_app,
   output reg [N_FDI-1:0] o_failsafe_input,
   output reg [N_FDO-1:0] o_failsafe_output,
   // status
   output reg o_safe_torque_off,
   output reg o_test_active,
   output reg o_test_ack,
   output reg o_ready,
   output reg o_motion_test_due_alarm,
   output reg o_io_test_due_alarm,
   output reg o_irq
);

   // ---------------------------------------------------------------
   // states
   // ---------------------------------------------------------------
   localparam ST_IDLE = 2'd0;
   localparam ST_IN = 2'd1;
   localparam ST_OUT = 2'd2;
   localparam ST_REL = 2'd3;

   reg [1:0] state_q;
   reg [3:0] step_q;
   reg [15:0] left_q;
   reg auto_run_q;
   reg auto_pend_q;
   reg fail_q;
   reg req_prev_q;
   reg [31:0] ctrl_q;
   reg [`FTS_IRQ_W-1:0] irq_stat_q;
   reg [`FTS_IRQ_W-1:0] irq_mask_q;
   reg [13:0] interval_q;
   reg [N_FDI-1:0] in_mask_q;
   reg [N_FDO-1:0] out_mask_q;
   reg [15:0] out_wait_q;
   reg [15:0] in_wait_q;
   reg [15:0] comm_q [0:5];
   reg [13:0] elapsed_q;
   reg due_q;
   reg [15:0] sample_q;

   wire ms_tick;
   wire hour_tick;
   reg [15:0] min_t;
   reg [15:0] wait_x;
   reg [15:0] wait_y;
   reg [15:0] step_len;
   reg [`FTS_IRQ_W-1:0] irq_set;
   reg [31:0] rdata;
   reg rerr;
   reg req_sel;
   reg req_edge;
   reg start_manual;
   reg start_auto;
   reg step_end;
   reg last_in;
   reg last_out;
   reg test_ok;
   reg timer_rst;
   integer k;

   wire apb_setup = i_psel & ~i_penable;
   wire apb_take = i_psel & i_penable & o_pready;
   wire apb_wr = apb_take & i_pwrite;
   wire busy = (state_q == ST_IN) | (state_q == ST_OUT);

   // ---------------------------------------------------------------
   // time base
   // ---------------------------------------------------------------
   fts_tick_gen #(
      .W(22),
      .PERIOD(CYC_PER_MS)
   ) u_ms_tick (
      .i_core_clk(i_core_clk),
      .i_reset(i_reset),
      .i_en(1'b1),
      .i_clr(1'b0),
      .o_tick(ms_tick)
   );

   // hour prescaler restarts with the elapsed count
   fts_tick_gen #(
      .W(22),
      .PERIOD(MS_PER_HOUR)
   ) u_hour_tick (
      .i_core_clk(i_core_clk),
      .i_reset(i_reset),
      .i_en(ms_tick),
      .i_clr(timer_rst),
      .o_tick(hour_tick)
   );

   // ---------------------------------------------------------------
   // wait and sample arithmetic
   // ---------------------------------------------------------------
   always @* begin
      min_t = comm_q[0];
      for (k = 1; k < 6; k = k + 1) begin
         if (comm_q[k] < min_t) begin
            min_t = comm_q[k];
         end
      end
      wait_x = `FTS_MIN_IN_WAIT_MS;
      if (sample_q > wait_x) begin
         wait_x = sample_q;
      end
      if (in_wait_q > wait_x) begin
         wait_x = in_wait_q;
      end
      wait_y = out_wait_q;
      if (sample_q > wait_y) begin
         wait_y = sample_q;
      end
      if (in_wait_q > wait_y) begin
         wait_y = in_wait_q;
      end
      // even steps and the last two output steps are samples, other odd steps are waits
      if (state_q == ST_OUT && step_q >= `FTS_OUT_PAIR_STEPS) begin
         step_len = sample_q;
      end else if (step_q[0] == 1'b0) begin
         step_len = sample_q;
      end else if (state_q == ST_OUT) begin
         step_len = wait_y;
      end else begin
         step_len = wait_x;
      end
   end

   // ---------------------------------------------------------------
   // request and sequence decisions
   // ---------------------------------------------------------------
   always @* begin
      req_sel = ctrl_q[`FTS_CTRL_SW_REQ];
      if (ctrl_q[`FTS_CTRL_SRC_SEL]) begin
         req_sel = req_sel | i_req_process_data_word;
      end else begin
         req_sel = req_sel | i_req_terminal;
      end
      req_edge = req_sel & ~req_prev_q;
      // edges outside idle are dropped, not queued
      start_manual = (state_q == ST_IDLE) & req_edge;
      // auto waits for a healthy link before each attempt
      start_auto = (state_q == ST_IDLE) & ~req_edge & auto_pend_q & i_chan_ok &
         (ctrl_q[`FTS_CTRL_SELFTEST_EN] | ctrl_q[`FTS_CTRL_IO_EN]);
      step_end = busy & ms_tick & (left_q <= 16'h0001);
      last_in = (state_q == ST_IN) & (step_q == `FTS_IN_STEPS - 4'h1);
      last_out = (state_q == ST_OUT) & (step_q == `FTS_OUT_STEPS - 4'h1);
      test_ok = step_end & last_out & i_chan_ok & ~fail_q;
      timer_rst = test_ok;
      irq_set = {`FTS_IRQ_W{1'b0}};
      // event is the alarm rising, so a shortened interval still reports
      irq_set[`FTS_IRQ_MOTION_DUE] = due_q & ~o_motion_test_due_alarm;
      irq_set[`FTS_IRQ_IO_DUE] = due_q & ~o_io_test_due_alarm &
         ((|in_mask_q) | (|out_mask_q));
      irq_set[`FTS_IRQ_DONE] = test_ok;
      irq_set[`FTS_IRQ_FAIL] = step_end & ~i_chan_ok;
      irq_set[`FTS_IRQ_REFUSED] = start_manual & i_safe_torque_off_selected;
   end

   // ---------------------------------------------------------------
   // test sequencer
   // ---------------------------------------------------------------
   always @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         state_q <= ST_IDLE;
         step_q <= 4'h0;
         left_q <= 16'h0000;
         auto_run_q <= 1'b0;
         auto_pend_q <= 1'b1;
         fail_q <= 1'b0;
         req_prev_q <= 1'b0;
         sample_q <= `FTS_COMM_RST;
      end else begin
         req_prev_q <= req_sel;
         sample_q <= min_t;
         case (state_q)
            ST_IDLE: begin
               if (start_manual && !i_safe_torque_off_selected) begin
                  state_q <= ST_IN;
                  auto_run_q <= 1'b0;
                  fail_q <= 1'b0;
                  step_q <= 4'h0;
                  left_q <= sample_q;
               end else if (start_manual) begin
                  state_q <= ST_REL;
                  fail_q <= 1'b1;
               end else if (start_auto) begin
                  // same steps as a manual run, and a success also restarts interval monitoring
                  state_q <= ST_IN;
                  auto_run_q <= 1'b1;
                  fail_q <= 1'b0;
                  step_q <= 4'h0;
                  left_q <= sample_q;
               end
            end
            ST_IN, ST_OUT: begin
               if (step_end && !i_chan_ok) begin
                  fail_q <= 1'b1;
                  state_q <= auto_run_q ? ST_IDLE : ST_REL;
               end else if (step_end && last_in) begin
                  state_q <= ST_OUT;
                  step_q <= 4'h0;
                  left_q <= sample_q;
               end else if (step_end && last_out) begin
                  state_q <= auto_run_q ? ST_IDLE : ST_REL;
                  if (auto_run_q) begin
                     auto_pend_q <= 1'b0;
                  end
               end else if (step_end) begin
                  step_q <= step_q + 4'h1;
                  left_q <= 16'h0000;
               end else if (left_q == 16'h0000) begin
                  left_q <= (step_len == 16'h0000) ? 16'h0001 : step_len;
               end else if (ms_tick) begin
                  left_q <= left_q - 16'h0001;
               end
            end
            ST_REL: begin
               if (!req_sel) begin
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // outputs toward drive and i/o
   // ---------------------------------------------------------------
   always @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         o_safe_torque_off <= 1'b0;
         o_test_active <= 1'b0;
         o_test_ack <= 1'b0;
         o_ready <= 1'b0;
         o_failsafe_input <= {N_FDI{1'b0}};
         o_failsafe_output <= {N_FDO{1'b0}};
         o_motion_test_due_alarm <= 1'b0;
         o_io_test_due_alarm <= 1'b0;
         o_irq <= 1'b0;
      end else begin
         o_test_active <= busy;
         o_safe_torque_off <= busy;
         if (busy) begin
            // consumers must ignore these while the test runs
            o_failsafe_input <= (o_failsafe_input & in_mask_q) |
               (i_failsafe_input & ~in_mask_q);
            if (state_q == ST_OUT) begin
               o_failsafe_output <= out_mask_q &
                  {N_FDO{step_q[0] & (step_q < `FTS_OUT_PAIR_STEPS)}};
            end else begin
               o_failsafe_output <= {N_FDO{1'b0}};
            end
         end else begin
            o_failsafe_input <= i_failsafe_input;
            o_failsafe_output <= i_failsafe_output_app;
         end
         if (state_q == ST_REL && !req_sel && !fail_q) begin
            o_test_ack <= 1'b1;
         end else if (start_manual || start_auto) begin
            o_test_ack <= 1'b0;
         end
         if (test_ok) begin
            o_ready <= 1'b1;
         end else if (start_manual || start_auto) begin
            o_ready <= 1'b0;
         end
         // alarm only; operation goes on
         o_motion_test_due_alarm <= due_q;
         o_io_test_due_alarm <= due_q & ((|in_mask_q) | (|out_mask_q));
         o_irq <= |(irq_stat_q & irq_mask_q);
      end
   end

   // ---------------------------------------------------------------
   // interval supervision
   // ---------------------------------------------------------------
   always @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         elapsed_q <= 14'h0000;
         due_q <= 1'b0;
      end else if (timer_rst) begin
         elapsed_q <= 14'h0000;
         due_q <= 1'b0;
      end else begin
         if (hour_tick && elapsed_q != 14'h3fff) begin
            elapsed_q <= elapsed_q + 14'h0001;
         end
         // stays set until a test succeeds or the block is reset
         if (elapsed_q >= interval_q) begin
            due_q <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // apb register file
   // ---------------------------------------------------------------
   always @* begin
      rdata = 32'h0000_0000;
      rerr = 1'b0;
      if (i_paddr == `FTS_OFF_CTRL) begin
         rdata = ctrl_q;
      end else if (i_paddr == `FTS_OFF_STATUS) begin
         rdata = {23'h000000, fail_q, auto_pend_q, due_q, o_ready, o_test_ack,
            o_safe_torque_off, state_q, busy};
      end else if (i_paddr == `FTS_OFF_IRQ_STAT) begin
         rdata[`FTS_IRQ_W-1:0] = irq_stat_q;
      end else if (i_paddr == `FTS_OFF_IRQ_MASK) begin
         rdata[`FTS_IRQ_W-1:0] = irq_mask_q;
      end else if (i_paddr == `FTS_OFF_INTERVAL) begin
         rdata[13:0] = interval_q;
      end else if (i_paddr == `FTS_OFF_IN_MASK) begin
         rdata[N_FDI-1:0] = in_mask_q;
      end else if (i_paddr == `FTS_OFF_OUT_MASK) begin
         rdata[N_FDO-1:0] = out_mask_q;
      end else if (i_paddr == `FTS_OFF_OUT_WAIT) begin
         rdata[15:0] = out_wait_q;
      end else if (i_paddr == `FTS_OFF_IN_WAIT) begin
         rdata[15:0] = in_wait_q;
      end else if (i_paddr == `FTS_OFF_ELAPSED) begin
         rdata[13:0] = elapsed_q;
      end else if (i_paddr == `FTS_OFF_SAMPLE) begin
         rdata[15:0] = sample_q;
      end else if (i_paddr >= `FTS_OFF_COMM0 && i_paddr <= `FTS_OFF_COMM5 &&
         i_paddr[1:0] == 2'b00) begin
         rdata[15:0] = comm_q[i_paddr[4:2] - 3'd0];
      end else begin
         rerr = 1'b1;
      end
   end

   always @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         o_pready <= 1'b0;
         o_prdata <= 32'h0000_0000;
         o_pslverr <= 1'b0;
         ctrl_q <= 32'h0000_0000;
         irq_stat_q <= {`FTS_IRQ_W{1'b0}};
         irq_mask_q <= {`FTS_IRQ_W{1'b0}};
         interval_q <= `FTS_INTERVAL_RST;
         in_mask_q <= {N_FDI{1'b0}};
         out_mask_q <= {N_FDO{1'b0}};
         out_wait_q <= `FTS_WAIT_RST;
         in_wait_q <= `FTS_WAIT_RST;
         for (k = 0; k < 6; k = k + 1) begin
            comm_q[k] <= `FTS_COMM_RST;
         end
      end else begin
         // one wait state: answer on the second access cycle
         o_pready <= i_psel & i_penable & ~o_pready;
         if (i_psel && i_penable && !o_pready) begin
            o_prdata <= i_pwrite ? 32'h0000_0000 : rdata;
            o_pslverr <= rerr;
         end else if (apb_setup) begin
            o_pslverr <= 1'b0;
         end
         // hardware set beats a clear in the same cycle
         if (apb_wr && i_paddr == `FTS_OFF_IRQ_STAT) begin
            irq_stat_q <= (irq_stat_q & ~i_pwdata[`FTS_IRQ_W-1:0]) | irq_set;
         end else begin
            irq_stat_q <= irq_stat_q | irq_set;
         end
         if (apb_wr) begin
            if (i_paddr == `FTS_OFF_CTRL) begin
               ctrl_q <= i_pwdata & `FTS_CTRL_MASK;
            end else if (i_paddr == `FTS_OFF_IRQ_MASK) begin
               irq_mask_q <= i_pwdata[`FTS_IRQ_W-1:0];
            end else if (i_paddr == `FTS_OFF_INTERVAL) begin
               interval_q <= i_pwdata[13:0];
            end else if (i_paddr == `FTS_OFF_IN_MASK) begin
               in_mask_q <= i_pwdata[N_FDI-1:0];
            end else if (i_paddr == `FTS_OFF_OUT_MASK) begin
               out_mask_q <= i_pwdata[N_FDO-1:0];
            end else if (i_paddr == `FTS_OFF_OUT_WAIT) begin
               out_wait_q <= i_pwdata[15:0];
            end else if (i_paddr == `FTS_OFF_IN_WAIT) begin
               in_wait_q <= i_pwdata[15:0];
            end else if (i_paddr >= `FTS_OFF_COMM0 && i_paddr <= `FTS_OFF_COMM5 &&
               i_paddr[1:0] == 2'b00) begin
               comm_q[i_paddr[4:2]] <= i_pwdata[15:0];
            end
         end
      end
   end

endmodule

`default_nettype wire

// file: rtl/fts_defines.vh
`ifndef FTS_DEFINES_VH
`define FTS_DEFINES_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define FTS_OFF_CTRL 8'h00
`define FTS_OFF_STATUS 8'h04
`define FTS_OFF_IRQ_STAT 8'h08
`define FTS_OFF_IRQ_MASK 8'h0c
`define FTS_OFF_INTERVAL 8'h10
`define FTS_OFF_IN_MASK 8'h14
`define FTS_OFF_OUT_MASK 8'h18
`define FTS_OFF_OUT_WAIT 8'h1c
`define FTS_OFF_IN_WAIT 8'h20
`define FTS_OFF_ELAPSED 8'h24
`define FTS_OFF_SAMPLE 8'h28
`define FTS_OFF_COMM0 8'h40
`define FTS_OFF_COMM5 8'h54

// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define FTS_CTRL_SW_REQ 0
`define FTS_CTRL_SRC_SEL 1
`define FTS_CTRL_SELFTEST_EN 6
`define FTS_CTRL_IO_EN 7
`define FTS_CTRL_MASK 32'h0000_00c3

// ---------------------------------------------------------------
// interrupt status fields
// ---------------------------------------------------------------
`define FTS_IRQ_MOTION_DUE 0
`define FTS_IRQ_IO_DUE 1
`define FTS_IRQ_DONE 2
`define FTS_IRQ_FAIL 3
`define FTS_IRQ_REFUSED 4
`define FTS_IRQ_W 5

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define FTS_INTERVAL_RST 14'h2238
`define FTS_COMM_RST 16'h0004
`define FTS_WAIT_RST 16'h0000

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define FTS_CLK_MHZ 250
`define FTS_MS_PER_HOUR 3600000
`define FTS_MIN_IN_WAIT_MS 16'h0014
`define FTS_IN_STEPS 4'h6
`define FTS_OUT_STEPS 4'he
`define FTS_OUT_PAIR_STEPS 4'hc

`endif

// file: rtl/fts_tick_gen.v
`timescale 1ns/10ps
`default_nettype none

// pulses once every PERIOD enabled cycles
module fts_tick_gen #(
   parameter W = 22,
   parameter PERIOD = 250000
) (
   // clock and reset
   input wire i_core_clk,
   input wire i_reset,
   // count control
   input wire i_en,
   input wire i_clr,
   // tick out
   output reg o_tick
);

   reg [W-1:0] cnt_q;

   always @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         cnt_q <= {W{1'b0}};
         o_tick <= 1'b0;
      end else if (i_clr) begin
         cnt_q <= {W{1'b0}};
         o_tick <= 1'b0;
      end else if (i_en) begin
         if (cnt_q == PERIOD[W-1:0] - 1'b1) begin
            cnt_q <= {W{1'b0}};
            o_tick <= 1'b1;
         end else begin
            cnt_q <= cnt_q + 1'b1;
            o_tick <= 1'b0;
         end
      end else begin
         o_tick <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// file: verification/fts_app_model.sv
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------
// application side of the test request
// ---------------------------------------------------------------
module fts_app_model (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset,
   // bench commands
   input wire logic i_start,
   input wire logic i_drop,
   input wire logic i_bad_sto,
   input wire logic [3:0] i_hold,
   // device status
   input wire logic i_active,
   input wire logic i_ready,
   // request lines
   output logic o_req,
   output logic o_sto_sel
);
   logic [3:0] wait_q;
   logic seen_q;
   // old ready may still stand at start, so count only after a run
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         o_req <= 1'b0;
         o_sto_sel <= 1'b0;
         wait_q <= 4'h0;
         seen_q <= 1'b0;
      end else begin
         o_sto_sel <= i_bad_sto;
         // drive sits at controlled standstill whenever a request starts
         if (i_start) begin
            o_req <= 1'b1;
            wait_q <= 4'h0;
            seen_q <= 1'b0;
         end else if (i_drop) begin
            o_req <= 1'b0;
         end else if (o_req && i_active) begin
            seen_q <= 1'b1;
         end else if (o_req && seen_q && i_ready) begin
            wait_q <= wait_q + 4'h1;
            if (wait_q == i_hold) begin
               o_req <= 1'b0;
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: verification/fts_scheduler_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------
// port checker
// ---------------------------------------------------------------
module fts_chk #(
   parameter N_FDI = 10,
   parameter N_FDO = 4
) (
   // clock and reset
   input wire i_core_clk,
   input wire i_reset,
   // fail-safe i/o
   input wire [N_FDI-1:0] i_failsafe_input,
   input wire [N_FDO-1:0] i_failsafe_output_app,
   input wire [N_FDI-1:0] o_failsafe_input,
   input wire [N_FDO-1:0] o_failsafe_output,
   // status
   input wire o_safe_torque_off,
   input wire o_test_active,
   input wire o_test_ack,
   input wire o_ready,
   input wire o_motion_test_due_alarm,
   input wire o_io_test_due_alarm
);
   // bound covers default waits; longer waits need a larger figure
   localparam int MAX_RUN = 800;
   logic [11:0] run_q;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_reset);
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         run_q <= 12'h000;
      end else begin
         run_q <= o_test_active ? run_q + 12'h001 : 12'h000;
      end
   end
   sequence s_start;
      $rose(o_test_active);
   endsequence
   sequence s_ready;
      $rose(o_ready);
   endsequence
   chk_sto_with_test: assert property (o_safe_torque_off == o_test_active)
      else $error("safe torque off differs from test active");
   chk_run_bounded: assert property (o_test_active |-> run_q < MAX_RUN)
      else $error("test run too long");
   chk_idle_outputs: assert property (!o_test_active |->
      o_failsafe_output == $past(i_failsafe_output_app))
      else $error("outputs not passed through while idle");
   chk_idle_inputs: assert property (!o_test_active |->
      o_failsafe_input == $past(i_failsafe_input))
      else $error("inputs not passed through while idle");
   chk_start_clears_ready: assert property (s_start |-> !o_ready)
      else $error("ready kept at test start");
   chk_ready_origin: assert property (s_ready |->
      $past(o_test_active) || $past(o_test_active, 2))
      else $error("ready without a finished test");
   chk_ack_after_ready: assert property ($rose(o_test_ack) |-> o_ready && !o_test_active)
      else $error("ack without success");
   chk_io_due_pair: assert property (o_io_test_due_alarm |-> o_motion_test_due_alarm)
      else $error("io due without motion due");
   chk_due_cleared: assert property (s_ready |-> ##[0:3] !o_motion_test_due_alarm)
      else $error("due alarm kept after success");
endmodule
`default_nettype wire
bind fts_scheduler fts_chk #(.N_FDI(N_FDI), .N_FDO(N_FDO)) fts_chk_i (
   .i_core_clk(i_core_clk), .i_reset(i_reset), .i_failsafe_input(i_failsafe_input),
   .i_failsafe_output_app(i_failsafe_output_app), .o_failsafe_input(o_failsafe_input),
   .o_failsafe_output(o_failsafe_output), .o_safe_torque_off(o_safe_torque_off),
   .o_test_active(o_test_active), .o_test_ack(o_test_ack), .o_ready(o_ready),
   .o_motion_test_due_alarm(o_motion_test_due_alarm),
   .o_io_test_due_alarm(o_io_test_due_alarm));

// file: verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "fts_defines.vh"
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin n_mismatch++; \
   $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
   logic clk, rst, psel, pen, pwr, rdy_p, serr, req_pd, ok, safe_torque_off, act, ack, rdy, md, iod, irq;
   logic start, drop, bad, use_pd, req, sto_sel, req_t;
   logic [7:0] pa;
   logic [31:0] pwd, prd, r;
   logic [9:0] fin, fin_o;
   logic [3:0] fapp, fout;
   int n_mismatch = 0;
   int samples_checked = 0;
   assign req_t = use_pd ? 1'b0 : req;
   assign req_pd = use_pd ? req : 1'b0;
   fts_scheduler #(.CYC_PER_MS(4), .MS_PER_HOUR(3)) fts_scheduler_i (
      .i_core_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(pa), .i_pwdata(pwd), .o_pready(rdy_p), .o_prdata(prd), .o_pslverr(serr),
      .i_req_terminal(req_t), .i_req_process_data_word(req_pd),
      .i_safe_torque_off_selected(sto_sel), .i_chan_ok(ok), .i_failsafe_input(fin),
      .i_failsafe_output_app(fapp), .o_failsafe_input(fin_o), .o_failsafe_output(fout),
      .o_safe_torque_off(safe_torque_off), .o_test_active(act), .o_test_ack(ack), .o_ready(rdy),
      .o_motion_test_due_alarm(md), .o_io_test_due_alarm(iod), .o_irq(irq));
   fts_app_model fts_app_model_i (.i_core_clk(clk), .i_reset(rst), .i_start(start),
      .i_drop(drop), .i_bad_sto(bad), .i_hold(4'h8), .i_active(act), .i_ready(rdy),
      .o_req(req), .o_sto_sel(sto_sel));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // ---------------------------------------------------------------
   // bus and wait tasks
   // ---------------------------------------------------------------
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (rdy_p !== 1'b1) @(posedge clk);
      r = prd;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0);
      `CHK(nm, e, r)
   endtask
   task wait_act(input logic v);
      int n;
      n = 0;
      while (act !== v && n < 3000) begin
         @(posedge clk);
         n++;
      end
      `CHK("test_active", v, act)
   endtask
   task pulse(input logic which);
      @(posedge clk);
      if (which) begin
         drop <= 1'b1;
      end else begin
         start <= 1'b1;
      end
      @(posedge clk);
      start <= 1'b0;
      drop <= 1'b0;
   endtask
   task wrap_up;
      $display("mismatches %0d of %0d checks", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge clk);
      n_mismatch++;
      wrap_up;
   end
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial begin
      {psel, pen, pwr, start, drop, bad, use_pd} = 7'h00;
      pa = 8'h00;
      pwd = 32'h0000_0000;
      rst = 1'b1;
      ok = 1'b1;
      fin = 10'h000;
      fapp = 4'h0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rd(`FTS_OFF_CTRL, 32'h0, "ctrl");
      rd(`FTS_OFF_INTERVAL, 32'h2238, "interval");
      rd(`FTS_OFF_COMM0, 32'h4, "comm0");
      rd(8'h30, 32'h0, "unmapped");
      `CHK("pslverr", 1'b1, serr)
      apb(1'b1, `FTS_OFF_COMM0 + 8'h0c, 32'h2);
      rd(`FTS_OFF_SAMPLE, 32'h2, "sample");
      apb(1'b1, `FTS_OFF_INTERVAL, 32'h1);
      apb(1'b1, `FTS_OFF_IRQ_MASK, 32'h1f);
      repeat (40) @(posedge clk);
      `CHK("motion_due", 1'b1, md)
      `CHK("io_due", 1'b0, iod)
      apb(1'b1, `FTS_OFF_IN_MASK, 32'h00f);
      apb(1'b1, `FTS_OFF_OUT_MASK, 32'h3);
      repeat (2) @(posedge clk);
      `CHK("io_due", 1'b1, iod)
      apb(1'b0, `FTS_OFF_IRQ_STAT, 32'h0);
      `CHK("irq_due_bits", 2'b11, r[1:0])
      `CHK("irq", 1'b1, irq)
      apb(1'b1, `FTS_OFF_IRQ_MASK, 32'h1c);
      apb(1'b1, `FTS_OFF_IRQ_STAT, 32'h1f);
      repeat (2) @(posedge clk);
      `CHK("irq_masked", 1'b0, irq)
      apb(1'b1, `FTS_OFF_CTRL, 32'hc0);
      wait_act(1'b1);
      repeat (20) @(posedge clk);
      ok <= 1'b0;
      wait_act(1'b0);
      `CHK("ready_abort", 1'b0, rdy)
      `CHK("irq_fail", 1'b1, irq)
      ok <= 1'b1;
      wait_act(1'b1);
      wait_act(1'b0);
      @(posedge clk);
      `CHK("ready_auto", 1'b1, rdy)
      `CHK("ack_auto", 1'b0, ack)
      `CHK("due_cleared", 1'b0, md)
      rd(`FTS_OFF_ELAPSED, 32'h0, "elapsed");
      apb(1'b1, `FTS_OFF_IRQ_STAT, 32'h1f);
      repeat (2) @(posedge clk);
      `CHK("irq_clear", 1'b0, irq)
      fin <= 10'h3ff;
      fapp <= 4'hf;
      pulse(1'b0);
      wait_act(1'b1);
      repeat (5) @(posedge clk);
      `CHK("sto", 1'b1, safe_torque_off)
      `CHK("unmasked_out", 2'b00, fout[3:2])
      fin <= 10'h000;
      apb(1'b1, `FTS_OFF_CTRL, 32'hc1);
      apb(1'b1, `FTS_OFF_CTRL, 32'hc0);
      `CHK("frozen_in", 10'h00f, fin_o)
      wait_act(1'b0);
      `CHK("ack_held", 1'b0, ack)
      repeat (20) @(posedge clk);
      `CHK("ack", 1'b1, ack)
      `CHK("no_retrigger", 1'b0, act)
      bad <= 1'b1;
      use_pd <= 1'b1;
      apb(1'b1, `FTS_OFF_CTRL, 32'hc2);
      pulse(1'b0);
      repeat (10) @(posedge clk);
      `CHK("refused", 1'b0, act)
      apb(1'b0, `FTS_OFF_IRQ_STAT, 32'h0);
      `CHK("irq_refused", 1'b1, r[4])
      pulse(1'b1);
      bad <= 1'b0;
      repeat (4) @(posedge clk);
      pulse(1'b0);
      wait_act(1'b1);
      ok <= 1'b0;
      wait_act(1'b0);
      `CHK("ready_manual_abort", 1'b0, rdy)
      pulse(1'b1);
      ok <= 1'b1;
      repeat (5) @(posedge clk);
      `CHK("ack_abort", 1'b0, ack)
      apb(1'b1, `FTS_OFF_CTRL, 32'hc1);
      wait_act(1'b1);
      wait_act(1'b0);
      `CHK("ready_channel", 1'b1, rdy)
      apb(1'b1, `FTS_OFF_CTRL, 32'hc0);
      repeat (2) @(posedge clk);
      `CHK("ack_channel", 1'b1, ack)
      wrap_up;
   end
endmodule
`default_nettype wire
